/* File: rtl/sgr_sgi_regs.sv */
// SGI generation registers and EL1 interface select register
`timescale 1ns/100ps
`default_nettype none

module sgr_sgi_regs #(
    parameter bit RS_IGNORE_WRITE = 1'b0   // Unsupported range: drop instead of zero
) (
    input  wire logic                      ref_clk,          // Processor clock
    input  wire logic                      rst,              // Asynchronous reset, high
    input  wire sgr_pkg::sgr_acc_s         acc,              // Register access request
    input  wire sgr_pkg::sgr_cfg_s         cfg,              // Trap and routing controls
    input  wire logic [sgr_pkg::TGT_W-1:0] ns_group0_permit, // Per target NS group 0 permit
    output var  sgr_pkg::sgr_rsp_s         rsp,              // Access answer
    output logic                           sgi_valid,        // Generate-SGI request pulse
    output var  sgr_pkg::sgr_sgi_s         sgi,              // Generate-SGI request data
    output logic                           sre_secure,       // Secure interface select bit
    output logic                           sre_nonsecure     // Non-secure interface select bit
);

    // ==========================================================
    // State
    typedef struct packed {
        logic              sre_s;
        logic              sre_ns;
        sgr_pkg::sgr_rsp_s rsp;
        logic              sgi_valid;
        sgr_pkg::sgr_sgi_s sgi;
    } sgr_state_s;

    sgr_state_s st;
    sgr_state_s next_st;

    // ==========================================================
    // Decode helpers
    logic                      secure_acc;
    logic                      sre_cur;
    logic                      both_el3_routing;
    logic                      hyp_routing;
    logic                      trap;
    logic [1:0]                trap_el;
    logic                      is_sgi;
    logic                      write_ok;
    logic [sgr_pkg::RS_W-1:0]  rs_raw;
    logic                      rs_drop;
    sgr_pkg::sgr_sgi_s         req;

    always_comb begin
        secure_acc       = (acc.el == sgr_pkg::EL3) || !acc.ns;
        sre_cur          = secure_acc ? st.sre_s : st.sre_ns;
        both_el3_routing = cfg.el3_present && cfg.scr_fiq && cfg.scr_irq;
        hyp_routing      = cfg.hyp_fiq_routing || cfg.hyp_irq_routing;
        is_sgi           = (acc.sel == sgr_pkg::SGR_REG_SGI0) ||
                           (acc.sel == sgr_pkg::SGR_REG_SGI1);
    end

    // Trap decision, priority: own level first, then EL2, then EL3
    always_comb begin
        trap    = 1'b0;
        trap_el = sgr_pkg::EL1;
        if (is_sgi && acc.write) begin
            case (acc.el)
                sgr_pkg::EL1: begin
                    if (!sre_cur) begin
                        trap    = 1'b1;
                        trap_el = sgr_pkg::EL1;
                    end else if (!secure_acc && cfg.el2_present && hyp_routing) begin
                        trap    = 1'b1;
                        trap_el = sgr_pkg::EL2;
                    end else if (!secure_acc && cfg.common_register_trap) begin
                        trap    = 1'b1;
                        trap_el = sgr_pkg::EL2;
                    end else if (secure_acc && both_el3_routing) begin
                        trap    = 1'b1;
                        trap_el = sgr_pkg::EL3;
                    end else if (!secure_acc && both_el3_routing && !hyp_routing) begin
                        trap    = 1'b1;
                        trap_el = sgr_pkg::EL3;
                    end
                end
                sgr_pkg::EL2: begin
                    if (!cfg.sre_el2) begin
                        trap    = 1'b1;
                        trap_el = sgr_pkg::EL2;
                    end else if (both_el3_routing) begin
                        trap    = 1'b1;
                        trap_el = sgr_pkg::EL3;
                    end
                end
                sgr_pkg::EL3: begin
                    if (!cfg.sre_el3) begin
                        trap    = 1'b1;
                        trap_el = sgr_pkg::EL3;
                    end
                end
                default: begin
                    trap    = 1'b0;
                    trap_el = sgr_pkg::EL1;
                end
            endcase
        end
    end

    // ==========================================================
    // Field extraction for the outgoing request
    always_comb begin
        req                  = '0;
        req.group            = (acc.sel == sgr_pkg::SGR_REG_SGI1);
        req.secure           = secure_acc;
        req.routing_mode_bit = acc.wdata[sgr_pkg::IRM_BIT];
        req.sgi_number       = acc.wdata[sgr_pkg::SGI_NUMBER_LO +: sgr_pkg::SGI_NUMBER_W];
        rs_raw               = acc.wdata[sgr_pkg::RS_LO +: sgr_pkg::RS_W];
        rs_drop              = 1'b0;
        // Selector only meaningful when both ends support it
        if (!cfg.range_select_support) begin
            req.range_selector = '0;
        end else if (!cfg.dist_range_support && (rs_raw != '0)) begin
            req.range_selector = '0;
            rs_drop            = RS_IGNORE_WRITE;
        end else begin
            req.range_selector = rs_raw;
        end
        if (!req.routing_mode_bit) begin
            req.affinity_level3 = acc.wdata[sgr_pkg::AFFINITY_LEVEL3_LO +: sgr_pkg::AFF_W];
            req.affinity_level2 = acc.wdata[sgr_pkg::AFFINITY_LEVEL2_LO +: sgr_pkg::AFF_W];
            req.affinity_level1 = acc.wdata[sgr_pkg::AFFINITY_LEVEL1_LO +: sgr_pkg::AFF_W];
            req.target_mask     = acc.wdata[sgr_pkg::TGT_LO +: sgr_pkg::TGT_W];
            // Non-secure group 0 only reaches permitted targets unless security is disabled
            if (!req.group && !secure_acc && !cfg.security_disable) begin
                req.target_mask = req.target_mask & ns_group0_permit;
            end
        end else begin
            req.affinity_level3 = '0;
            req.affinity_level2 = '0;
            req.affinity_level1 = '0;
            req.target_mask     = '0;
            req.range_selector  = '0;
        end
    end

    // Distributor never back-pressures, so the request is a plain pulse
    assign write_ok = acc.valid && acc.write && is_sgi &&
                      (acc.el != sgr_pkg::EL0) && !trap && !rs_drop;

    // ==========================================================
    // Next state
    always_comb begin
        next_st           = st;
        next_st.rsp       = '0;
        next_st.sgi_valid = 1'b0;
        if (acc.valid) begin
            next_st.rsp.valid = 1'b1;
            case (acc.sel)
                sgr_pkg::SGR_REG_SGI0, sgr_pkg::SGR_REG_SGI1: begin
                    if ((acc.el == sgr_pkg::EL0) || !acc.write) begin
                        next_st.rsp.undef = 1'b1;
                    end else if (trap) begin
                        next_st.rsp.trap    = 1'b1;
                        next_st.rsp.trap_el = trap_el;
                    end
                end
                sgr_pkg::SGR_REG_SEL: begin
                    if (acc.el == sgr_pkg::EL0) begin
                        next_st.rsp.undef = 1'b1;
                    end else if (acc.write) begin
                        if (secure_acc) begin
                            next_st.sre_s  = acc.wdata[sgr_pkg::SEL_SRE_BIT];
                        end else begin
                            next_st.sre_ns = acc.wdata[sgr_pkg::SEL_SRE_BIT];
                        end
                    end else begin
                        // Upper bits read as zero
                        next_st.rsp.rdata[sgr_pkg::SEL_SRE_BIT] = sre_cur;
                    end
                end
                default: begin
                    next_st.rsp.undef = 1'b1;
                end
            endcase
        end
        if (write_ok) begin
            next_st.sgi_valid = 1'b1;
            next_st.sgi       = req;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st        <= '0;
            st.sre_s  <= sgr_pkg::SRE_RESET;
            st.sre_ns <= sgr_pkg::SRE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign rsp           = st.rsp;
    assign sgi_valid     = st.sgi_valid;
    assign sgi           = st.sgi;
    assign sre_secure    = st.sre_s;
    assign sre_nonsecure = st.sre_ns;

    // ==========================================================
    // Checks
    a_broadcast_clears: assert property (@(posedge ref_clk) disable iff (rst)
        sgi_valid && sgi.routing_mode_bit |-> (sgi.target_mask == '0) &&
        (sgi.affinity_level1 == '0) && (sgi.affinity_level2 == '0) &&
        (sgi.affinity_level3 == '0))
        else $error("broadcast request carries affinity or targets");

    a_el3_secure: assert property (@(posedge ref_clk) disable iff (rst)
        acc.valid && acc.write && is_sgi && (acc.el == sgr_pkg::EL3) && !trap
        |=> sgi_valid && sgi.secure)
        else $error("EL3 write not marked secure");

    a_disabled_trap: assert property (@(posedge ref_clk) disable iff (rst)
        acc.valid && acc.write && is_sgi && (acc.el == sgr_pkg::EL2) && !cfg.sre_el2
        |=> rsp.trap && (rsp.trap_el == sgr_pkg::EL2) && !sgi_valid)
        else $error("disabled EL2 write not trapped to EL2");

    a_hyp_trap: assert property (@(posedge ref_clk) disable iff (rst)
        acc.valid && acc.write && is_sgi && (acc.el == sgr_pkg::EL1) && acc.ns &&
        st.sre_ns && cfg.el2_present && cfg.hyp_irq_routing
        |=> rsp.trap && (rsp.trap_el == sgr_pkg::EL2))
        else $error("routed NS EL1 write not trapped to EL2");

    a_el2_to_el3: assert property (@(posedge ref_clk) disable iff (rst)
        acc.valid && acc.write && is_sgi && (acc.el == sgr_pkg::EL2) && cfg.sre_el2 &&
        cfg.el3_present && cfg.scr_fiq && cfg.scr_irq
        |=> rsp.trap && (rsp.trap_el == sgr_pkg::EL3))
        else $error("EL2 write not trapped to EL3");

    a_no_rs_support: assert property (@(posedge ref_clk) disable iff (rst)
        acc.valid && !cfg.range_select_support ##1 sgi_valid |-> sgi.range_selector == '0)
        else $error("range selector passed without support");

    a_ns_group0: assert property (@(posedge ref_clk) disable iff (rst)
        write_ok && (acc.sel == sgr_pkg::SGR_REG_SGI0) && acc.ns &&
        (acc.el != sgr_pkg::EL3) && !cfg.security_disable
        |=> (sgi.target_mask & ~$past(ns_group0_permit)) == '0)
        else $error("unpermitted group 0 target reached");

    a_el0_undef: assert property (@(posedge ref_clk) disable iff (rst)
        acc.valid && is_sgi && ((acc.el == sgr_pkg::EL0) || !acc.write)
        |=> rsp.undef && !sgi_valid && (rsp.rdata == '0))
        else $error("SGI register read or EL0 access not refused");

    a_one_request: assert property (@(posedge ref_clk) disable iff (rst)
        sgi_valid |-> $past(acc.valid) && $past(is_sgi) && rsp.valid && !rsp.trap)
        else $error("SGI request without accepted write");

    a_sel_write: assert property (@(posedge ref_clk) disable iff (rst)
        acc.valid && acc.write && (acc.sel == sgr_pkg::SGR_REG_SEL) &&
        (acc.el == sgr_pkg::EL3) ##1 acc.valid && !acc.write &&
        (acc.sel == sgr_pkg::SGR_REG_SEL) && (acc.el == sgr_pkg::EL3)
        |=> rsp.rdata == {63'h0, $past(acc.wdata[0], 2)})
        else $error("interface select readback mismatch");

endmodule

`default_nettype wire

/* File: shared/sgr_pkg.sv */
// Constants and types shared by the SGI generation register block
package sgr_pkg;

    // ==========================================================
    // SGI generation register fields
    localparam int SGI_DATA_W    = 64;
    localparam int TGT_LO        = 0;
    localparam int TGT_W         = 16;
    localparam int AFFINITY_LEVEL1_LO       = 16;
    localparam int SGI_NUMBER_LO      = 24;
    localparam int SGI_NUMBER_W       = 4;
    localparam int AFFINITY_LEVEL2_LO       = 32;
    localparam int IRM_BIT       = 40;
    localparam int RS_LO         = 44;
    localparam int RS_W          = 4;
    localparam int AFFINITY_LEVEL3_LO       = 48;
    localparam int AFF_W         = 8;

    // ==========================================================
    // Interface select register fields
    localparam int SEL_REG_W     = 32;
    localparam int SEL_SRE_BIT   = 0;
    localparam logic SRE_RESET   = 1'h0;

    // ==========================================================
    // Exception levels
    localparam logic [1:0] EL0   = 2'h0;
    localparam logic [1:0] EL1   = 2'h1;
    localparam logic [1:0] EL2   = 2'h2;
    localparam logic [1:0] EL3   = 2'h3;

    typedef enum logic [1:0] {
        SGR_REG_SGI0,
        SGR_REG_SGI1,
        SGR_REG_SEL,
        SGR_REG_NONE
    } sgr_reg_e;

    // Access from the instruction interface
    typedef struct packed {
        logic                  valid;
        logic                  write;
        sgr_reg_e              sel;
        logic [1:0]            el;
        logic                  ns;
        logic [SGI_DATA_W-1:0] wdata;
    } sgr_acc_s;

    // Trap and routing controls held elsewhere in the core
    typedef struct packed {
        logic el2_present;
        logic el3_present;
        logic sre_el2;
        logic sre_el3;
        logic scr_fiq;
        logic scr_irq;
        logic hyp_fiq_routing;
        logic hyp_irq_routing;
        logic common_register_trap;
        logic range_select_support;
        logic dist_range_support;
        logic security_disable;
    } sgr_cfg_s;

    // Generate-SGI request to the distributor
    typedef struct packed {
        logic             group;
        logic             secure;
        logic             routing_mode_bit;
        logic [AFF_W-1:0] affinity_level3;
        logic [AFF_W-1:0] affinity_level2;
        logic [AFF_W-1:0] affinity_level1;
        logic [RS_W-1:0]  range_selector;
        logic [SGI_NUMBER_W-1:0] sgi_number;
        logic [TGT_W-1:0] target_mask;
    } sgr_sgi_s;

    // Answer to the instruction interface
    typedef struct packed {
        logic                  valid;
        logic                  trap;
        logic [1:0]            trap_el;
        logic                  undef;
        logic [SGI_DATA_W-1:0] rdata;
    } sgr_rsp_s;

endpackage

/* File: tb/sgr_dist_model.sv */
// Behavioural distributor that takes generate-SGI requests
`timescale 1ns/100ps
`default_nettype none

module sgr_dist_model #(
    parameter logic [15:0] PE_MASK = 16'h00ff   // Affinity-0 values with a real PE
) (
    input  wire logic              ref_clk,    // Processor clock
    input  wire logic              rst,        // Asynchronous reset, high
    input  wire logic              sgi_valid,  // Request pulse
    input  wire sgr_pkg::sgr_sgi_s sgi,        // Request data
    output logic [15:0]            accept_cnt, // Requests taken
    output logic [15:0]            delivered   // Targets of last request
);
    // =========================================================
    // Accept every request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            accept_cnt <= 16'h0;
            delivered  <= 16'h0;
        end else if (sgi_valid) begin
            accept_cnt <= accept_cnt + 16'h1;
            delivered  <= sgi.target_mask & PE_MASK;
        end
    end
endmodule

`default_nettype wire

/* File: tb/sgr_sgi_regs_tb.sv */
// Self-checking testbench of the SGI generation register block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); end end

module sgr_sgi_regs_tb;
    localparam logic [15:0] PE_MASK = 16'h00ff;
    logic              ref_clk = 1'b0;
    logic              rst     = 1'b1;
    sgr_pkg::sgr_acc_s acc     = '0;
    sgr_pkg::sgr_cfg_s cfg     = '1;
    logic [15:0]       permit  = 16'h0;
    sgr_pkg::sgr_rsp_s rsp;
    sgr_pkg::sgr_sgi_s sgi;
    logic              sgi_valid, sre_secure, sre_nonsecure;
    logic [15:0]       accept_cnt, delivered, n_exp, last_tgt;
    logic              sre_s, sre_ns;
    int                error_cnt = 0;
    int                checks    = 0;

    always #5 ref_clk = ~ref_clk;

    sgr_sgi_regs i_sgr_sgi_regs (.ref_clk(ref_clk), .rst(rst), .acc(acc), .cfg(cfg),
        .ns_group0_permit(permit), .rsp(rsp), .sgi_valid(sgi_valid), .sgi(sgi),
        .sre_secure(sre_secure), .sre_nonsecure(sre_nonsecure));
    sgr_dist_model #(.PE_MASK(PE_MASK)) i_sgr_dist_model (.ref_clk(ref_clk), .rst(rst),
        .sgi_valid(sgi_valid), .sgi(sgi), .accept_cnt(accept_cnt), .delivered(delivered));

    // =========================================================
    // Expected answer, updates the select copies on a write
    task automatic expect_of(input sgr_pkg::sgr_acc_s a, output sgr_pkg::sgr_rsp_s er,
                             output logic ev, output sgr_pkg::sgr_sgi_s es);
        logic       sec;
        logic [1:0] tel;
        logic       tr;
        logic       en;
        logic [63:0] d;
        er = '0; ev = 1'b0; es = '0; er.valid = 1'b1; tr = 1'b0; tel = 2'h0;
        d = a.wdata;
        sec = (a.el == sgr_pkg::EL3) || !a.ns;
        en = sec ? sre_s : sre_ns;
        if (a.el == sgr_pkg::EL0 || a.sel == sgr_pkg::SGR_REG_NONE ||
            (!a.write && a.sel != sgr_pkg::SGR_REG_SEL)) begin
            er.undef = 1'b1;
        end else if (a.sel == sgr_pkg::SGR_REG_SEL) begin
            er.rdata = {63'h0, en};
            if (a.write && sec) sre_s = d[0];
            if (a.write && !sec) sre_ns = d[0];
        end else begin
            if (a.el == sgr_pkg::EL1) begin
                if (!en) {tr, tel} = {1'b1, sgr_pkg::EL1};
                else if (a.ns && cfg.el2_present &&
                         (cfg.hyp_fiq_routing || cfg.hyp_irq_routing))
                    {tr, tel} = {1'b1, sgr_pkg::EL2};
                else if (a.ns && cfg.common_register_trap) {tr, tel} = {1'b1, sgr_pkg::EL2};
                else if (cfg.el3_present && cfg.scr_fiq && cfg.scr_irq &&
                         (!a.ns || !(cfg.hyp_fiq_routing || cfg.hyp_irq_routing)))
                    {tr, tel} = {1'b1, sgr_pkg::EL3};
            end else if (a.el == sgr_pkg::EL2) begin
                if (!cfg.sre_el2) {tr, tel} = {1'b1, sgr_pkg::EL2};
                else if (cfg.el3_present && cfg.scr_fiq && cfg.scr_irq)
                    {tr, tel} = {1'b1, sgr_pkg::EL3};
            end else if (!cfg.sre_el3) {tr, tel} = {1'b1, sgr_pkg::EL3};
            er.trap = tr;
            er.trap_el = tel;
            if (!tr) begin
                ev = 1'b1;
                es.group = (a.sel == sgr_pkg::SGR_REG_SGI1);
                es.secure = sec;
                es.routing_mode_bit = d[sgr_pkg::IRM_BIT];
                es.sgi_number = d[sgr_pkg::SGI_NUMBER_LO +: sgr_pkg::SGI_NUMBER_W];
                if (!d[sgr_pkg::IRM_BIT]) begin
                    es.affinity_level3 = d[sgr_pkg::AFFINITY_LEVEL3_LO +: sgr_pkg::AFF_W];
                    es.affinity_level2 = d[sgr_pkg::AFFINITY_LEVEL2_LO +: sgr_pkg::AFF_W];
                    es.affinity_level1 = d[sgr_pkg::AFFINITY_LEVEL1_LO +: sgr_pkg::AFF_W];
                    if (cfg.range_select_support && cfg.dist_range_support)
                        es.range_selector = d[sgr_pkg::RS_LO +: sgr_pkg::RS_W];
                    es.target_mask = d[sgr_pkg::TGT_LO +: sgr_pkg::TGT_W];
                    if (!es.group && !sec && !cfg.security_disable)
                        es.target_mask = es.target_mask & permit;
                end
            end
        end
    endtask

    // =========================================================
    // One access, answered at the next edge
    task automatic access(input sgr_pkg::sgr_acc_s a);
        sgr_pkg::sgr_rsp_s er;
        sgr_pkg::sgr_sgi_s es;
        logic ev;
        acc = a;
        expect_of(a, er, ev, es);
        @(posedge ref_clk);
        #1;
        `CHK("rsp", {er.valid, er.trap, er.trap_el, er.undef},
             {rsp.valid, rsp.trap, rsp.trap_el, rsp.undef})
        if (!a.write) `CHK("rdata", er.rdata, rsp.rdata)
        `CHK("sgi_valid", ev, sgi_valid)
        if (ev) `CHK("sgi", es, sgi)
        `CHK("sre", {sre_s, sre_ns}, {sre_secure, sre_nonsecure})
        if (ev) begin
            n_exp = n_exp + 16'h1;
            last_tgt = es.target_mask & PE_MASK;
        end
    endtask

    function automatic sgr_pkg::sgr_acc_s mk(logic w, sgr_pkg::sgr_reg_e s, logic [1:0] el,
                                             logic ns, logic [63:0] d);
        mk = '{valid: 1'b1, write: w, sel: s, el: el, ns: ns, wdata: d};
    endfunction

    task automatic do_reset();
        rst = 1'b1;
        sre_s = 1'b0;
        sre_ns = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        `CHK("reset", 4'h0, {rsp.valid, sgi_valid, sre_secure, sre_nonsecure})
    endtask

    task automatic stop_test();
        if (error_cnt == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        #(30000 * 10);
        error_cnt++;
        stop_test();
    end

    initial begin
        sgr_pkg::sgr_acc_s a;
        sgr_pkg::sgr_cfg_s c;
        n_exp = 16'h0;
        last_tgt = 16'h0;
        void'($urandom(8653));
        do_reset();
        access(mk(1'b1, sgr_pkg::SGR_REG_SGI1, sgr_pkg::EL1, 1'b0, 64'h1));
        access(mk(1'b0, sgr_pkg::SGR_REG_SEL, sgr_pkg::EL1, 1'b1, 64'h0));
        access(mk(1'b1, sgr_pkg::SGR_REG_SEL, sgr_pkg::EL0, 1'b1, 64'h1));
        access(mk(1'b1, sgr_pkg::SGR_REG_NONE, sgr_pkg::EL1, 1'b1, 64'h1));
        access(mk(1'b1, sgr_pkg::SGR_REG_SEL, sgr_pkg::EL1, 1'b0, 64'hffffffff));
        access(mk(1'b1, sgr_pkg::SGR_REG_SEL, sgr_pkg::EL1, 1'b1, 64'h1));
        access(mk(1'b0, sgr_pkg::SGR_REG_SGI0, sgr_pkg::EL3, 1'b1, 64'h0));
        for (int i = 0; i < 600; i++) begin
            c = sgr_pkg::sgr_cfg_s'(12'($urandom));
            c.sre_el2 = ($urandom % 4) != 0;
            c.sre_el3 = ($urandom % 4) != 0;
            cfg = c;
            permit = 16'($urandom);
            a = mk(($urandom % 5) != 0, sgr_pkg::sgr_reg_e'($urandom % 4), 2'($urandom),
                   1'($urandom), {$urandom, $urandom});
            if (a.el == sgr_pkg::EL2) a.ns = 1'b1;
            if (a.sel == sgr_pkg::SGR_REG_SEL && a.write) a.wdata[0] = ($urandom % 4) != 0;
            if (i == 300) begin
                acc = '0;
                do_reset();
                n_exp = 16'h0;
                last_tgt = 16'h0;
            end
            access(a);
        end
        acc = '0;
        @(posedge ref_clk);
        #1;
        `CHK("accepted", n_exp, accept_cnt)
        `CHK("delivered", last_tgt, delivered)
        stop_test();
    end
endmodule

`default_nettype wire
